/* src/readback_pkg.sv */
// Purpose: Constants, types and helpers for the configuration read-back engine
// Assumes: One clock, host pins synchronised before use
// Notes: Slot opcodes and controller register indexes are local choices
// Behaviour
// RULE_01 - Bridge register read blocks further commands until its response returns.
// RULE_02 - Host sends 32-bit beats of a bridge read payload from bits 127:96 down.
// RULE_03 - Input and output bus never carry data together; device sets direction.
// RULE_04 - One frame per read command, blocks back to back, gaps between frames; the engine strobes a block at most every other cycle.
// RULE_05 - Host disables scrubbing before memory read-back; register reads always allowed.
// RULE_06 - Bits MSB to LSB within a word; words go out lowest first.
// RULE_07 - Every read returns a full 128-bit packet, zero padded.
// RULE_08 - Width 128: register value on bits 31:0, bits 127:32 zero.
// RULE_09 - Width 32: value in one beat, then three zero beats.
// RULE_10 - Width 16: bits 15:0, then 31:16, then six zero beats.
// RULE_11 - Width 8: four bytes lowest first, then twelve zero beats.
// RULE_12 - Width 1: bit 0 through bit 31, then 96 zero beats.
// RULE_13 - Two-stage data pipe: frame data emerges two read commands later.
// RULE_14 - Clock-enable command starts clocking the second-stage data registers.
// RULE_15 - Clock-disable stops them; later reads drain what remains in the pipe.
// RULE_16 - Host writes the frame address register before each frame read.
// RULE_17 - Single frame: enable, address, read, disable, read, read captures frame.
// RULE_18 - Multi-frame: first two reads discarded, then frame k-2, disable, two reads.
// RULE_19 - Host captures read data only while read-valid is high.
// RULE_20 - A register read command sits in the last slot of its payload.
// RULE_21 - Device drives output-enable low while the shared bus must output.
// RULE_22 - Host holds active-low chip select low to present commands.
// RULE_23 - Read-valid stays low for discarded responses and padding beats.
package readback_pkg;

	localparam int unsigned PAY_W = 128;
	localparam int unsigned SLOT_W = 32;
	localparam int unsigned FRAME_BLOCKS = 73;
	localparam int unsigned OP_LO = 28;
	localparam logic [15:0] CREG_FRAME_ADDR = 16'h0000;
	localparam logic [15:0] CREG_SCRATCH = 16'h0001;
	localparam logic [15:0] CREG_STATUS = 16'h0002;

	typedef enum logic [2:0] {
		WID_1 = 3'h0,
		WID_8 = 3'h1,
		WID_16 = 3'h2,
		WID_32 = 3'h3,
		WID_128 = 3'h4
	} width_t;

	typedef enum logic [3:0] {
		OP_NOP = 4'h0,
		OP_REG_WRITE = 4'h1,
		OP_REG_READ = 4'h2,
		OP_BRIDGE_READ = 4'h3,
		OP_CLK_ENABLE = 4'h4,
		OP_CLK_DISABLE = 4'h5,
		OP_MEM_READ = 4'h6
	} op_t;

	typedef enum logic [1:0] {
		ENT_FRAME = 2'h0,
		ENT_REG = 2'h1,
		ENT_DISCARD = 2'h2
	} ent_t;

	typedef struct packed {
		ent_t kind;
		logic [PAY_W-1:0] data;
	} entry_t;

	typedef struct packed {
		logic valid;
		logic [31:0] addr;
	} pipe_slot_t;

	// Bits carried per beat
	function automatic logic [7:0] width_bits(width_t w);
		case (w)
			WID_8: width_bits = 8'h08;
			WID_16: width_bits = 8'h10;
			WID_32: width_bits = 8'h20;
			WID_128: width_bits = 8'h80;
			default: width_bits = 8'h01;
		endcase
	endfunction

	// Beats per 128-bit packet
	function automatic logic [7:0] pkt_beats(width_t w);
		case (w)
			WID_8: pkt_beats = 8'h10;
			WID_16: pkt_beats = 8'h08;
			WID_32: pkt_beats = 8'h04;
			WID_128: pkt_beats = 8'h01;
			default: pkt_beats = 8'h80;
		endcase
	endfunction

	// Beats holding a 32-bit register value
	function automatic logic [7:0] reg_beats(width_t w);
		case (w)
			WID_8: reg_beats = 8'h04;
			WID_16: reg_beats = 8'h02;
			WID_32: reg_beats = 8'h01;
			WID_128: reg_beats = 8'h01;
			default: reg_beats = 8'h20;
		endcase
	endfunction

	function automatic logic [PAY_W-1:0] low_chunk(width_t w, logic [PAY_W-1:0] d);
		case (w)
			WID_8: low_chunk = {120'h0, d[7:0]};
			WID_16: low_chunk = {112'h0, d[15:0]};
			WID_32: low_chunk = {96'h0, d[31:0]};
			WID_128: low_chunk = d;
			default: low_chunk = {127'h0, d[0]};
		endcase
	endfunction

endpackage

/* src/two_entry_buffer.sv */
// Purpose: Two-entry valid/ready buffer
// Assumes: Single clock, asynchronous active-low reset
// Notes: Full when both entries hold data
`timescale 1ns/1ns
module two_entry_buffer #(
	parameter int unsigned W = 8
) (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [W-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [W-1:0] out_data_out
);
	logic [W-1:0] mem_r [0:1];
	logic [W-1:0] mem_nxt [0:1];
	logic wr_r, wr_nxt, rd_r, rd_nxt;
	logic [1:0] cnt_r, cnt_nxt;
	logic push, pop;

	assign in_ready_out = (cnt_r != 2'h2);
	assign out_valid_out = (cnt_r != 2'h0);
	assign out_data_out = mem_r[rd_r];
	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;

	always_comb begin
		mem_nxt[0] = mem_r[0];
		mem_nxt[1] = mem_r[1];
		if (push) begin
			mem_nxt[wr_r] = in_data_in;
		end
		wr_nxt = push ? ~wr_r : wr_r;
		rd_nxt = pop ? ~rd_r : rd_r;
		cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			mem_r[0] <= '0;
			mem_r[1] <= '0;
			wr_r <= 1'b0;
			rd_r <= 1'b0;
			cnt_r <= 2'h0;
		end else begin
			mem_r[0] <= mem_nxt[0];
			mem_r[1] <= mem_nxt[1];
			wr_r <= wr_nxt;
			rd_r <= rd_nxt;
			cnt_r <= cnt_nxt;
		end
	end
endmodule // two_entry_buffer

/* src/config_readback_engine.sv */
// Purpose: Host-port command interpreter and read-back engine
// Assumes: Host pins asynchronous to CLK_IN; fabric and bridge on CLK_IN
// Notes: Fabric returns block data in the same cycle as FRAME_RD_OUT
`timescale 1ns/1ns
module config_readback_engine
	import readback_pkg::*;
#(
	parameter int unsigned BLOCKS = FRAME_BLOCKS
) (
	input wire logic CLK_IN,
	input wire logic ARST_N_IN,
	input wire logic CS_N_IN,
	input wire logic [2:0] WIDTH_SEL_IN,
	input wire logic HOST_READY_IN,
	input wire logic [PAY_W-1:0] DQ_IN,
	output logic [PAY_W-1:0] DQ_OUT,
	output logic DQ_OE_OUT,
	output logic DQ_OEN_N_OUT,
	output logic DQ_VALID_OUT,
	output logic CMD_READY_OUT,
	output logic FABRIC_CLK_EN_OUT,
	output logic FRAME_RD_OUT,
	output logic [31:0] FRAME_ADDR_OUT,
	output logic [7:0] FRAME_BLOCK_OUT,
	input wire logic [PAY_W-1:0] FRAME_DATA_IN,
	output logic BRIDGE_RD_OUT,
	output logic [23:0] BRIDGE_ADDR_OUT,
	input wire logic BRIDGE_RESP_VALID_IN,
	input wire logic [31:0] BRIDGE_RESP_DATA_IN
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_EXEC = 3'b001,
		ST_FETCH = 3'b011,
		ST_DRAIN = 3'b010,
		ST_PUSH = 3'b110,
		ST_BWAIT = 3'b111
	} state_t;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic cs_n_s1, cs_n_s2, rdy_s1, rdy_s2;
	logic [2:0] wid_s1, wid_s2;
	logic [PAY_W-1:0] dq_s1, dq_s2;

	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			cs_n_s1 <= 1'b1;
			cs_n_s2 <= 1'b1;
			rdy_s1 <= 1'b0;
			rdy_s2 <= 1'b0;
			wid_s1 <= 3'h0;
			wid_s2 <= 3'h0;
			dq_s1 <= '0;
			dq_s2 <= '0;
		end else begin
			cs_n_s1 <= CS_N_IN;
			cs_n_s2 <= cs_n_s1;
			rdy_s1 <= HOST_READY_IN;
			rdy_s2 <= rdy_s1;
			wid_s1 <= WIDTH_SEL_IN;
			wid_s2 <= wid_s1;
			dq_s1 <= DQ_IN;
			dq_s2 <= dq_s1;
		end
	end

	// ----------------------------------------------------------------
	// Command state
	// ----------------------------------------------------------------
	state_t st_r, st_nxt;
	width_t width_r, width_nxt;
	logic [PAY_W-1:0] pay_r, pay_nxt;
	logic [7:0] beat_r, beat_nxt, blk_r, blk_nxt;
	logic [1:0] slot_r, slot_nxt;
	logic wr_pend_r, wr_pend_nxt, clk_en_r, clk_en_nxt, rd_r, rd_nxt, discard_r, discard_nxt;
	logic brd_r, brd_nxt;
	logic [15:0] wr_addr_r, wr_addr_nxt;
	logic [31:0] frame_addr_r, frame_addr_nxt, scratch_r, scratch_nxt, fetch_addr_r, fetch_addr_nxt;
	logic [23:0] baddr_r, baddr_nxt;
	pipe_slot_t stage1_r, stage1_nxt, stage2_r, stage2_nxt;
	entry_t hold_r, hold_nxt, buf_in, buf_out;
	logic buf_in_valid, buf_in_ready, buf_out_valid, buf_pop, ser_idle, out_dir_r, out_dir_nxt;
	logic [31:0] slot, reg_val;
	logic [6:0] slot_base;

	assign slot_base = {~slot_r, 5'h00};
	assign slot = pay_r[slot_base +: SLOT_W];

	always_comb begin
		case (slot[15:0])
			CREG_FRAME_ADDR: reg_val = frame_addr_r;
			CREG_SCRATCH: reg_val = scratch_r;
			CREG_STATUS: reg_val = {29'h0, stage2_r.valid, stage1_r.valid, clk_en_r};
			default: reg_val = 32'h0;
		endcase
	end

	always_comb begin
		st_nxt = st_r;
		width_nxt = width_r;
		pay_nxt = pay_r;
		beat_nxt = beat_r;
		blk_nxt = blk_r;
		slot_nxt = slot_r;
		wr_pend_nxt = wr_pend_r;
		wr_addr_nxt = wr_addr_r;
		clk_en_nxt = clk_en_r;
		rd_nxt = 1'b0;
		brd_nxt = 1'b0;
		baddr_nxt = baddr_r;
		discard_nxt = discard_r;
		frame_addr_nxt = frame_addr_r;
		scratch_nxt = scratch_r;
		fetch_addr_nxt = fetch_addr_r;
		stage1_nxt = stage1_r;
		stage2_nxt = stage2_r;
		hold_nxt = hold_r;
		buf_in_valid = 1'b0;
		buf_in = hold_r;
		unique case (st_r)
			ST_IDLE: begin
				if (beat_r == 8'h00) begin
					width_nxt = width_t'(wid_s2);
				end
				if (!cs_n_s2 && !out_dir_r) begin // see RULE_22, see RULE_03
					pay_nxt = (pay_r << width_bits(width_r)) | low_chunk(width_r, dq_s2); // see RULE_02
					beat_nxt = beat_r + 8'h01;
					if (beat_r == pkt_beats(width_r) - 8'h01) begin
						beat_nxt = 8'h00;
						slot_nxt = 2'h0;
						st_nxt = ST_EXEC;
					end
				end
			end
			ST_EXEC: begin
				st_nxt = (slot_r == 2'h3) ? ST_DRAIN : ST_EXEC;
				slot_nxt = slot_r + 2'h1;
				if (wr_pend_r) begin
					wr_pend_nxt = 1'b0;
					if (wr_addr_r == CREG_FRAME_ADDR) begin
						frame_addr_nxt = slot; // see RULE_16
					end else if (wr_addr_r == CREG_SCRATCH) begin
						scratch_nxt = slot;
					end
				end else begin
					case (op_t'(slot[SLOT_W-1:OP_LO]))
						OP_REG_WRITE: begin
							wr_pend_nxt = 1'b1;
							wr_addr_nxt = slot[15:0];
						end
						OP_REG_READ: begin
							hold_nxt = '{kind: ENT_REG, data: {96'h0, reg_val}}; // see RULE_07
							st_nxt = ST_PUSH;
						end
						OP_BRIDGE_READ: begin
							brd_nxt = 1'b1;
							baddr_nxt = slot[23:0];
							st_nxt = ST_BWAIT; // see RULE_01
						end
						OP_CLK_ENABLE: clk_en_nxt = 1'b1; // see RULE_14
						OP_CLK_DISABLE: clk_en_nxt = 1'b0; // see RULE_15
						OP_MEM_READ: begin
							// Oldest stage answers, new address always enters but is valid only while clocked
							fetch_addr_nxt = stage2_r.addr; // see RULE_13
							discard_nxt = !stage2_r.valid; // see RULE_23
							stage2_nxt = stage1_r;
							stage1_nxt = '{valid: clk_en_r, addr: frame_addr_r}; // see RULE_14, see RULE_15
							blk_nxt = 8'h00;
							st_nxt = ST_FETCH;
						end
						default: ;
					endcase
				end
			end
			ST_BWAIT: begin
				if (BRIDGE_RESP_VALID_IN) begin
					hold_nxt = '{kind: ENT_REG, data: {96'h0, BRIDGE_RESP_DATA_IN}}; // see RULE_01
					st_nxt = ST_PUSH;
				end
			end
			ST_PUSH: begin
				buf_in_valid = 1'b1;
				if (buf_in_ready) begin
					st_nxt = (slot_r == 2'h0) ? ST_DRAIN : ST_EXEC;
				end
			end
			ST_FETCH: begin
				// One frame per command, block strobes at most every other cycle
				if (discard_r) begin
					buf_in = '{kind: ENT_DISCARD, data: '0};
					buf_in_valid = 1'b1;
					if (buf_in_ready) begin
						blk_nxt = blk_r + 8'h01;
					end
				end else begin
					buf_in = '{kind: ENT_FRAME, data: FRAME_DATA_IN}; // see RULE_04
					buf_in_valid = rd_r;
					if (!rd_r && buf_in_ready && blk_r != BLOCKS[7:0]) begin
						rd_nxt = 1'b1;
						blk_nxt = blk_r + 8'h01;
					end
				end
				if (blk_r == BLOCKS[7:0] && !rd_r) begin
					st_nxt = (slot_r == 2'h0) ? ST_DRAIN : ST_EXEC;
				end
			end
			ST_DRAIN: begin
				if (!buf_out_valid && ser_idle) begin
					st_nxt = ST_IDLE;
				end
			end
			default: st_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			st_r <= ST_IDLE;
			width_r <= WID_1;
			pay_r <= '0;
			beat_r <= 8'h00;
			blk_r <= 8'h00;
			slot_r <= 2'h0;
			wr_pend_r <= 1'b0;
			wr_addr_r <= 16'h0000;
			clk_en_r <= 1'b0;
			rd_r <= 1'b0;
			brd_r <= 1'b0;
			baddr_r <= 24'h000000;
			discard_r <= 1'b0;
			frame_addr_r <= 32'h0;
			scratch_r <= 32'h0;
			fetch_addr_r <= 32'h0;
			stage1_r <= '0;
			stage2_r <= '0;
			hold_r <= '0;
		end else begin
			st_r <= st_nxt;
			width_r <= width_nxt;
			pay_r <= pay_nxt;
			beat_r <= beat_nxt;
			blk_r <= blk_nxt;
			slot_r <= slot_nxt;
			wr_pend_r <= wr_pend_nxt;
			wr_addr_r <= wr_addr_nxt;
			clk_en_r <= clk_en_nxt;
			rd_r <= rd_nxt;
			brd_r <= brd_nxt;
			baddr_r <= baddr_nxt;
			discard_r <= discard_nxt;
			frame_addr_r <= frame_addr_nxt;
			scratch_r <= scratch_nxt;
			fetch_addr_r <= fetch_addr_nxt;
			stage1_r <= stage1_nxt;
			stage2_r <= stage2_nxt;
			hold_r <= hold_nxt;
		end
	end

	assign CMD_READY_OUT = (st_r == ST_IDLE) && !out_dir_r;
	assign FABRIC_CLK_EN_OUT = clk_en_r;
	assign FRAME_RD_OUT = rd_r;
	assign FRAME_ADDR_OUT = fetch_addr_r;
	assign FRAME_BLOCK_OUT = blk_r - 8'h01;
	assign BRIDGE_RD_OUT = brd_r;
	assign BRIDGE_ADDR_OUT = baddr_r;

	two_entry_buffer #(
		.W($bits(entry_t))
	) u_buf (
		.clk_in(CLK_IN),
		.arst_n_in(ARST_N_IN),
		.in_valid_in(buf_in_valid),
		.in_ready_out(buf_in_ready),
		.in_data_in(buf_in),
		.out_valid_out(buf_out_valid),
		.out_ready_in(buf_pop),
		.out_data_out(buf_out)
	);

	// ----------------------------------------------------------------
	// Output serializer
	// ----------------------------------------------------------------
	logic [PAY_W-1:0] sh_r, sh_nxt, dq_r, dq_nxt;
	logic [7:0] left_r, left_nxt, sbeat_r, sbeat_nxt;
	ent_t kind_r, kind_nxt;
	logic vld_r, vld_nxt;

	assign ser_idle = (left_r == 8'h00);
	assign buf_pop = ser_idle && buf_out_valid;

	always_comb begin
		sh_nxt = sh_r;
		dq_nxt = dq_r;
		left_nxt = left_r;
		sbeat_nxt = sbeat_r;
		kind_nxt = kind_r;
		vld_nxt = 1'b0;
		out_dir_nxt = out_dir_r;
		if (buf_pop) begin
			sh_nxt = buf_out.data;
			kind_nxt = buf_out.kind;
			left_nxt = pkt_beats(width_r); // see RULE_07
			sbeat_nxt = 8'h00;
			out_dir_nxt = 1'b1; // see RULE_21
		end else if (!ser_idle && rdy_s2) begin
			// Low chunk first across beats, natural order inside a beat
			dq_nxt = low_chunk(width_r, sh_r); // see RULE_06, see RULE_08, see RULE_12
			sh_nxt = sh_r >> width_bits(width_r);
			left_nxt = left_r - 8'h01;
			sbeat_nxt = sbeat_r + 8'h01;
			vld_nxt = (kind_r == ENT_FRAME) || (kind_r == ENT_REG && sbeat_r < reg_beats(width_r)); // see RULE_09, see RULE_10, see RULE_11, see RULE_23
		end else if (st_r == ST_IDLE) begin
			out_dir_nxt = 1'b0; // see RULE_03
		end
	end

	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			sh_r <= '0;
			dq_r <= '0;
			left_r <= 8'h00;
			sbeat_r <= 8'h00;
			kind_r <= ENT_DISCARD;
			vld_r <= 1'b0;
			out_dir_r <= 1'b0;
		end else begin
			sh_r <= sh_nxt;
			dq_r <= dq_nxt;
			left_r <= left_nxt;
			sbeat_r <= sbeat_nxt;
			kind_r <= kind_nxt;
			vld_r <= vld_nxt;
			out_dir_r <= out_dir_nxt;
		end
	end

	assign DQ_OUT = dq_r;
	assign DQ_VALID_OUT = vld_r; // see RULE_19
	assign DQ_OE_OUT = out_dir_r;
	assign DQ_OEN_N_OUT = !out_dir_r; // see RULE_21
endmodule // config_readback_engine

/* tb/readback_checker_assertions.sv */
// Purpose: Port-level checks of the read-back engine
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Attached to the engine by bind
`timescale 1ns/1ns
module readback_checker
	import readback_pkg::*;
#(
	parameter int unsigned BLOCKS = FRAME_BLOCKS
) (
	input wire logic CLK_IN,
	input wire logic ARST_N_IN,
	input wire logic CMD_READY_OUT,
	input wire logic DQ_OE_OUT,
	input wire logic DQ_OEN_N_OUT,
	input wire logic DQ_VALID_OUT,
	input wire logic FABRIC_CLK_EN_OUT,
	input wire logic FRAME_RD_OUT,
	input wire logic [31:0] FRAME_ADDR_OUT,
	input wire logic [7:0] FRAME_BLOCK_OUT,
	input wire logic BRIDGE_RD_OUT,
	input wire logic BRIDGE_RESP_VALID_IN
);
	logic pend_r, pend_nxt;
	logic [31:0] addr_r, addr_nxt;
	logic [7:0] blk_r, blk_nxt;
	// ----------------------------------------
	// Helper state
	// ----------------------------------------
	always_comb begin
		pend_nxt = BRIDGE_RD_OUT | (pend_r & ~BRIDGE_RESP_VALID_IN);
		addr_nxt = FRAME_RD_OUT ? FRAME_ADDR_OUT : addr_r;
		blk_nxt = FRAME_RD_OUT ? FRAME_BLOCK_OUT : blk_r;
	end
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			pend_r <= 1'b0;
			addr_r <= 32'h0;
			blk_r <= 8'h00;
		end else begin
			pend_r <= pend_nxt;
			addr_r <= addr_nxt;
			blk_r <= blk_nxt;
		end
	end
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!ARST_N_IN);
	oen_inverse_a: assert property (DQ_OEN_N_OUT == !DQ_OE_OUT)
		else $error("direction outputs disagree");
	valid_needs_oe_a: assert property (DQ_VALID_OUT |-> DQ_OE_OUT)
		else $error("valid beat with bus not driven");
	out_blocks_in_a: assert property (DQ_OE_OUT |-> !CMD_READY_OUT)
		else $error("input taken while bus drives");
	bridge_block_a: assert property (BRIDGE_RD_OUT |-> !pend_r)
		else $error("bridge read while one is pending");
	strobe_gap_a: assert property (FRAME_RD_OUT |=> !FRAME_RD_OUT)
		else $error("block strobes too close");
	block_range_a: assert property (FRAME_RD_OUT |-> 32'(FRAME_BLOCK_OUT) < BLOCKS)
		else $error("block index beyond frame");
	block_seq_a: assert property (FRAME_RD_OUT && FRAME_BLOCK_OUT != 8'h00
		|-> FRAME_BLOCK_OUT == blk_r + 8'h01 && FRAME_ADDR_OUT == addr_r)
		else $error("frame fetch not one frame in order");
	clk_en_quiet_a: assert property ($changed(FABRIC_CLK_EN_OUT) |-> !DQ_OE_OUT && !FRAME_RD_OUT)
		else $error("clock enable moved during read");
	resp_to_valid_a: assert property (BRIDGE_RESP_VALID_IN |-> ##[1:40] DQ_VALID_OUT)
		else $error("bridge data never returned");
	cover property (BRIDGE_RESP_VALID_IN);
	cover property (FRAME_RD_OUT && FRAME_BLOCK_OUT != 8'h00);
	cover property (DQ_OE_OUT && !DQ_VALID_OUT);
endmodule // readback_checker

bind config_readback_engine readback_checker #(.BLOCKS(BLOCKS)) chk_i (.CLK_IN(CLK_IN),
	.ARST_N_IN(ARST_N_IN), .CMD_READY_OUT(CMD_READY_OUT), .DQ_OE_OUT(DQ_OE_OUT),
	.DQ_OEN_N_OUT(DQ_OEN_N_OUT), .DQ_VALID_OUT(DQ_VALID_OUT), .FABRIC_CLK_EN_OUT(FABRIC_CLK_EN_OUT),
	.FRAME_RD_OUT(FRAME_RD_OUT), .FRAME_ADDR_OUT(FRAME_ADDR_OUT), .FRAME_BLOCK_OUT(FRAME_BLOCK_OUT),
	.BRIDGE_RD_OUT(BRIDGE_RD_OUT), .BRIDGE_RESP_VALID_IN(BRIDGE_RESP_VALID_IN));

/* tb/host_model.sv */
// Purpose: Host side of the command port
// Assumes: Drives at the falling edge
// Notes: Released data lines show the inverse of the last beat
`timescale 1ns/1ns
module host_model (
	input wire logic clk_in,
	input wire logic cmd_ready_in,
	input wire logic oe_in,
	input wire logic valid_in,
	input wire logic [127:0] dq_in,
	output logic cs_n_out,
	output logic [2:0] wid_out,
	output logic hrdy_out,
	output logic [127:0] dq_out
);
	logic [127:0] cap[$];
	logic [127:0] msk;
	logic stall;
	int w;
	int late;
	initial begin
		cs_n_out = 1'b1;
		wid_out = 3'h3;
		hrdy_out = 1'b1;
		dq_out = 128'h0;
		stall = 1'b0;
		late = 0;
		w = 32;
		msk = 128'hFFFFFFFF;
	end
	task set_w(input int i);
		int t[5] = '{1, 8, 16, 32, 128};
		@(negedge clk_in);
		w = t[i];
		wid_out <= 3'(i);
		msk = (w == 128) ? '1 : (128'h1 << w) - 128'h1;
	endtask
	always @(negedge clk_in) hrdy_out <= stall ? 1'($urandom % 2) : 1'b1;
	always @(posedge clk_in) if (valid_in) cap.push_back(dq_in);
	// Payload beats, top chunk first, then wait until the port is idle
	task send(input logic [127:0] p);
		int n;
		int k;
		n = 128 / w;
		for (int i = 0; i < n; i++) begin
			@(negedge clk_in);
			cs_n_out <= 1'b0;
			dq_out <= (p >> ((n - 1 - i) * w)) & msk;
		end
		@(negedge clk_in);
		cs_n_out <= 1'b1;
		dq_out <= ~dq_out;
		k = 0;
		for (int t = 0; t < 30000 && k < 16; t++) begin
			@(posedge clk_in);
			#1;
			k = (cmd_ready_in && !oe_in) ? k + 1 : 0;
		end
		if (k < 16) late++;
	endtask
endmodule // host_model

/* tb/tb_config_readback_engine.sv */
// Purpose: Self-checking bench of the read-back engine
// Assumes: Fabric answers at the falling edge within the strobe cycle
// Notes: Frames shortened to two blocks
`timescale 1ns/1ns
module tb_config_readback_engine;
	import readback_pkg::*;
	localparam int BL = 2;
	logic clk, arst_n, cs_n, hrdy, oe, oen_n, dv, crdy, cen, frd, brd, brv, s1v, s2v, ce;
	logic [2:0] wid;
	logic [127:0] dq, dqo, fdata;
	logic [127:0] eq[$];
	logic [31:0] fad, bdat, v, fa, s1a, s2a;
	logic [23:0] badr, bad;
	logic [7:0] fblk;
	int err_count, checked, bcnt;
	config_readback_engine #(.BLOCKS(BL)) uut (.CLK_IN(clk), .ARST_N_IN(arst_n), .CS_N_IN(cs_n),
		.WIDTH_SEL_IN(wid), .HOST_READY_IN(hrdy), .DQ_IN(dq), .DQ_OUT(dqo), .DQ_OE_OUT(oe),
		.DQ_OEN_N_OUT(oen_n), .DQ_VALID_OUT(dv), .CMD_READY_OUT(crdy), .FABRIC_CLK_EN_OUT(cen),
		.FRAME_RD_OUT(frd), .FRAME_ADDR_OUT(fad), .FRAME_BLOCK_OUT(fblk), .FRAME_DATA_IN(fdata),
		.BRIDGE_RD_OUT(brd), .BRIDGE_ADDR_OUT(badr), .BRIDGE_RESP_VALID_IN(brv), .BRIDGE_RESP_DATA_IN(bdat));
	host_model hst (.clk_in(clk), .cmd_ready_in(crdy), .oe_in(oe), .valid_in(dv), .dq_in(dqo),
		.cs_n_out(cs_n), .wid_out(wid), .hrdy_out(hrdy), .dq_out(dq));
	always #25 clk = ~clk;
	// ----------------------------------------
	// Fabric and bridge responders
	// ----------------------------------------
	always @(negedge clk) fdata <= frd ? {fad, 88'h0, fblk} : ~fdata;
	always @(negedge clk) begin
		brv <= 1'b0;
		if (brd) begin
			bcnt <= 1 + $urandom % 6;
			bad <= badr;
		end else if (bcnt == 1) begin
			brv <= 1'b1;
			bdat <= {8'h3C, bad};
			bcnt <= 0;
		end else if (bcnt > 1) bcnt <= bcnt - 1;
		else bdat <= ~bdat;
	end
	// ----------------------------------------
	// Model and checks
	// ----------------------------------------
	task chk(input logic [127:0] s, input logic [127:0] e);
		checked++;
		if (s !== e) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task exp_pkt(input logic [127:0] p, input int nb);
		for (int j = 0; j < nb; j++) eq.push_back((p >> (j * hst.w)) & hst.msk);
	endtask
	task cmp_cap;
		chk(128'(hst.late), 128'h0);
		chk(128'(hst.cap.size()), 128'(eq.size()));
		for (int i = 0; i < eq.size() && i < hst.cap.size(); i++) chk(hst.cap[i] & hst.msk, eq[i]);
		hst.cap.delete();
		eq.delete();
	endtask
	function automatic logic [127:0] pl(input logic [31:0] s);
		return {96'h0, s};
	endfunction
	function automatic logic [127:0] wr(input logic [15:0] a, input logic [31:0] d);
		return {OP_REG_WRITE, 12'h000, a, d, 64'h0};
	endfunction
	task mem_rd;
		hst.send(pl({OP_MEM_READ, 28'h0}));
		if (s2v) for (int b = 0; b < BL; b++) exp_pkt({s2a, 88'h0, 8'(b)}, 128 / hst.w);
		s2v = s1v;
		s2a = s1a;
		s1v = ce;
		s1a = fa;
		cmp_cap;
	endtask
	task frames(input int n);
		ce = 1'b1;
		hst.send({OP_CLK_ENABLE, 124'h0}); // Scrubbing never runs here
		chk(128'(cen), 128'h1);
		for (int k = 0; k < n; k++) begin
			fa = $urandom;
			hst.send(wr(CREG_FRAME_ADDR, fa));
			mem_rd;
		end
		ce = 1'b0;
		hst.send({OP_CLK_DISABLE, 124'h0});
		chk(128'(cen), 128'h0);
		hst.send(pl({OP_REG_READ, 12'h000, CREG_STATUS}));
		exp_pkt({125'h0, s2v, s1v, ce}, hst.w > 32 ? 1 : 32 / hst.w);
		cmp_cap;
		mem_rd;
		mem_rd;
	endtask
	task print_verdict;
		$display("counts: checked %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#4000000;
		err_count++;
		print_verdict;
	end
	initial begin
		clk = 0;
		arst_n = 0;
		fdata = 0;
		brv = 0;
		bdat = 0;
		bcnt = 0;
		err_count = 0;
		checked = 0;
		{s1v, s2v, ce, fa, s1a, s2a} = '0;
		v = $urandom(74);
		repeat (8) @(posedge clk);
		@(negedge clk) arst_n = 1;
		@(posedge clk);
		#1;
		chk(128'({oe, oen_n, dv, cen, frd, brd}), 128'h10);
		$display("test reset done");
		for (int i = 0; i < 5; i++) begin
			hst.set_w(i);
			v = $urandom;
			hst.send(wr(CREG_SCRATCH, v));
			hst.send(pl({OP_REG_READ, 12'h000, CREG_SCRATCH}));
			exp_pkt({96'h0, v}, i == 4 ? 1 : 32 / hst.w);
			hst.send(pl({OP_REG_READ, 12'h000, 16'h0123}));
			exp_pkt(128'h0, i == 4 ? 1 : 32 / hst.w);
			cmp_cap;
		end
		$display("test widths done");
		hst.set_w(3);
		for (int i = 0; i < 3; i++) begin
			v = $urandom;
			hst.send(pl({OP_BRIDGE_READ, 4'h0, v[23:0]}));
			exp_pkt({96'h0, 8'h3C, v[23:0]}, 1);
		end
		cmp_cap;
		$display("test bridge done");
		hst.stall = 1'b1;
		frames(4);
		hst.stall = 1'b0;
		hst.set_w(4);
		frames(1);
		$display("test frames done");
		print_verdict;
	end
endmodule // tb_config_readback_engine
